// *** acs_params.svh ***
// Offsets, field positions, reset values and counts of the regeneration/status block
`ifndef ACS_PARAMS_SVH
`define ACS_PARAMS_SVH

// Register offsets
`define ACS_OFS_TOL        8'h10
`define ACS_OFS_CS0        8'h36
`define ACS_OFS_CS1        8'h37
`define ACS_OFS_CS2        8'h38
`define ACS_OFS_CS3        8'h39
`define ACS_OFS_CS4        8'h3a
`define ACS_OFS_BUF0       8'h5b
`define ACS_OFS_BUF1       8'h5c
`define ACS_OFS_BUF2       8'h5d
`define ACS_OFS_BUF3       8'h5e
`define ACS_OFS_BUF4       8'h5f
`define ACS_OFS_RAW        8'h65
`define ACS_OFS_CHG        8'h7e
`define ACS_OFS_CLR        8'h7f
`define ACS_OFS_CTL        8'h80
`define ACS_OFS_IRQ        8'h81

// Field positions
`define ACS_RAW_SEEN_BIT   1
`define ACS_RAW_VALID_BIT  7
`define ACS_CHG_N_BIT      3
`define ACS_CHG_CTO_BIT    4
`define ACS_CTL_MASK_A_BIT 0
`define ACS_CTL_MASK_B_BIT 1
`define ACS_CTL_IRQ_EN_BIT 2
`define ACS_CTL_MUTE_BIT   5

// Reset values
`define ACS_TOL_RST        6'h25
`define ACS_CTL_RST        8'h00

// Counts
`define ACS_CS_BITS        6'h28
`define ACS_CS_IDLE        6'h3f
`define ACS_CS_CHAN0       3'h0

`endif

// *** acs_pkg.sv ***
// Types shared by the regeneration/status block
package acs_pkg;

    // Regeneration tracker state
    typedef struct packed {
        logic [19:0] div_q;       // Last accepted N
        logic [19:0] cyc_q;       // Last accepted CTS
        logic        seen_q;      // Packet seen since link reset
        logic        div_chg_q;   // Sticky N change
        logic        over_q;      // Sticky CTS over tolerance
        logic        over_irq_q;  // Latched interrupt status
    } acs_trk_type;

    // Channel status collector state
    typedef struct packed {
        logic [39:0] sh_q;        // Bits being gathered
        logic [39:0] hold_q;      // Last complete 40 bits
        logic [5:0]  idx_q;       // Next bit position, idle code when waiting
        logic        valid_q;     // Complete block held
    } acs_col_type;

    // Register file state
    typedef struct packed {
        logic [5:0]  tol_q;       // CTS tolerance
        logic [7:0]  ctl_q;       // Masks and enables
        logic [39:0] buf_q;       // Snapshot of CTS and N
        logic [7:0]  rdata_q;     // Read data
        logic        rvalid_q;    // Read data strobe
    } acs_reg_type;

endpackage : acs_pkg

// *** acs_track.sv ***
// Regeneration packet tracker: stores N and CTS and raises change flags
`timescale 1ns/1ps
`include "acs_params.svh"

module acs_track
    import acs_pkg::*;
(
    input  wire logic        mclk,          // Core clock
    input  wire logic        nrst,          // Async reset, active low
    input  wire logic        link_rst,      // Link reset condition
    input  wire logic        pkt_stb,       // Regeneration packet accepted
    input  wire logic [19:0] pkt_div,       // N from packet
    input  wire logic [19:0] pkt_cyc,       // CTS from packet
    input  wire logic [5:0]  tol,           // CTS tolerance in LSBs
    input  wire logic        irq_en,        // Latch interrupt status
    input  wire logic        div_clr,       // Clear N change flag
    input  wire logic        over_clr,      // Clear CTS flags
    output logic      [19:0] div_val,       // Stored N
    output logic      [19:0] cyc_val,       // Stored CTS
    output logic             seen,          // Packet seen
    output logic             div_chg,       // Sticky N change
    output logic             over,          // Sticky CTS over tolerance
    output logic             over_irq       // Latched interrupt status
);

    acs_trk_type s_q;                       // Registered state
    acs_trk_type s_d;                       // Next state
    logic [19:0] diff;                      // Magnitude of CTS step
    logic        div_ev;                    // N differs this packet
    logic        over_ev;                   // CTS step above tolerance

    // Compare against stored values before they are replaced
    always_comb begin
        diff    = (pkt_cyc >= s_q.cyc_q) ? pkt_cyc - s_q.cyc_q : s_q.cyc_q - pkt_cyc;
        div_ev  = pkt_stb && s_q.seen_q && (pkt_div != s_q.div_q);     // see R6, R19
        over_ev = pkt_stb && s_q.seen_q && (diff > {14'h0000, tol});  // see R7, R9, R19
        s_d = s_q;
        // Set wins over clear so no event is lost
        if (div_clr) begin
            s_d.div_chg_q = 1'b0;
        end
        if (over_clr) begin
            s_d.over_q     = 1'b0;
            s_d.over_irq_q = 1'b0;
        end
        if (div_ev) begin
            s_d.div_chg_q = 1'b1; // see R6
        end
        if (over_ev) begin
            s_d.over_q = 1'b1; // see R7
            if (irq_en) begin
                s_d.over_irq_q = 1'b1; // see R9
            end
        end
        if (pkt_stb) begin
            s_d.div_q  = pkt_div; // see R3, R19
            s_d.cyc_q  = pkt_cyc; // see R4, R19
            s_d.seen_q = 1'b1; // see R5
        end else if (link_rst) begin
            s_d.seen_q = 1'b0; // see R5
        end
    end

    // State register
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign div_val  = s_q.div_q;
    assign cyc_val  = s_q.cyc_q;
    assign seen     = s_q.seen_q;
    assign div_chg  = s_q.div_chg_q;
    assign over     = s_q.over_q;
    assign over_irq = s_q.over_irq_q;

endmodule : acs_track

// *** acs_collect.sv ***
// Channel status collector: gathers the first 40 bits of channel 0 per block
`timescale 1ns/1ps
`include "acs_params.svh"

module acs_collect
    import acs_pkg::*;
(
    input  wire logic        mclk,          // Core clock
    input  wire logic        nrst,          // Async reset, active low
    input  wire logic        link_rst,      // Link reset condition
    input  wire logic        bit_stb,       // Channel status bit present
    input  wire logic        bit_val,       // Channel status bit value
    input  wire logic [2:0]  bit_chan,      // Audio channel of the bit
    input  wire logic        blk_start,     // Bit is the first of a block
    output logic      [39:0] cs_data,       // Last complete 40 bits
    output logic             cs_valid       // Complete block held
);

    acs_col_type s_q;                       // Registered state
    acs_col_type s_d;                       // Next state
    logic        take;                      // Bit belongs to channel 0

    // Collect bits, restart on each block start
    always_comb begin
        take = bit_stb && (bit_chan == `ACS_CS_CHAN0);                // see R10
        s_d  = s_q;
        if (take && blk_start) begin
            s_d.sh_q    = {39'h0, bit_val};
            s_d.idx_q   = 6'h01;
        end else if (take && (s_q.idx_q < `ACS_CS_BITS)) begin
            s_d.sh_q[s_q.idx_q] = bit_val;
            s_d.idx_q = s_q.idx_q + 6'h01;
        end
        // Bits after the fortieth are ignored until the next block
        if (take && (s_q.idx_q == `ACS_CS_BITS - 6'h01) && !blk_start) begin
            s_d.hold_q  = s_d.sh_q;                                   // see R10
            s_d.valid_q = 1'b1;                                       // see R11
            s_d.idx_q   = `ACS_CS_IDLE;
        end
        if (link_rst) begin
            s_d.valid_q = 1'b0;
            s_d.idx_q   = `ACS_CS_IDLE;
        end
    end

    // State register
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            s_q       <= '0;
            s_q.idx_q <= `ACS_CS_IDLE;
        end else begin
            s_q <= s_d;
        end
    end

    assign cs_data  = s_q.hold_q;
    assign cs_valid = s_q.valid_q;

endmodule : acs_collect

// *** acs_top.sv ***
// Audio clock regeneration readback and channel status register block
//
// How it works
// R1: Reading 0x5B snapshots N and CTS
// R2: Block read returns one coherent snapshot
// R3: N readback, zero until first packet
// R4: CTS readback over three bytes from 0x5B
// R5: Packet-seen bit, cleared by link reset
// R6: Sticky N-changed bit, cleared by software
// R7: Sticky CTS-over-tolerance bit, software cleared
// R8: Six-bit writable tolerance, reset 100101
// R9: Tolerance drives mute, status and interrupt
// R10: Channel status taken from channel 0
// R11: Valid after 40 bits correctly collected
// R12: Valid bit drives two masked interrupts
// R13: Byte 0 bits 0-2 at fixed positions
// R14: Emphasis and mode fields reported
// R15: Category code byte, resets zero
// R16: Source low nibble, channel high nibble
// R17: Sampling frequency field codes reported
// R18: Clock accuracy field codes reported
// R19: Compare with stored values, then update
`timescale 1ns/1ps
`include "acs_params.svh"

module acs_top
    import acs_pkg::*;
(
    input  wire logic        mclk,          // Core clock, 25 MHz
    input  wire logic        nrst,          // Async reset, active low
    input  wire logic        link_rst,      // Link reset condition, active high
    input  wire logic        pkt_stb,       // Regeneration packet accepted
    input  wire logic [19:0] pkt_div,       // N of that packet
    input  wire logic [19:0] pkt_cyc,       // CTS of that packet
    input  wire logic        cs_bit_stb,    // Channel status bit present
    input  wire logic        cs_bit,        // Channel status bit value
    input  wire logic [2:0]  cs_chan,       // Audio channel of the bit
    input  wire logic        cs_blk_start,  // First bit of a block
    input  wire logic [7:0]  reg_addr,      // Register offset
    input  wire logic        reg_wr,        // Write strobe
    input  wire logic [7:0]  reg_wdata,     // Write data
    input  wire logic        reg_rd,        // Read strobe
    output logic      [7:0]  reg_rdata,     // Read data
    output logic             reg_rvalid,    // Read data strobe
    output logic             int_a,         // Interrupt output A
    output logic             int_b,         // Interrupt output B
    output logic             mute_on_cycle_count_jump, // Mute request
    output logic             cs_fs_reserved,  // Sampling code reserved
    output logic             cs_acc_reserved  // Accuracy code reserved
);

    // Local state and wires
    acs_reg_type s_q;                       // Registered state
    acs_reg_type s_d;                       // Next state
    logic [19:0] div_val;                   // Stored N
    logic [19:0] cyc_val;                   // Stored CTS
    logic        regen_packet_seen;         // Packet seen flag
    logic        div_chg;                   // Sticky N change
    logic        cycle_count_over_tolerance;       // Sticky CTS flag
    logic        cycle_count_over_tolerance_irq;   // Latched irq status
    logic        regen_divider_changed_clear;      // N flag clear pulse
    logic        cycle_count_over_tolerance_clear; // CTS flag clear pulse
    logic [39:0] cs_data;                   // Collected channel status
    logic        cs_valid;                  // Channel status valid
    logic        chan_status_valid_mask_a;  // Mask for output A
    logic        chan_status_valid_mask_b;  // Mask for output B
    logic [39:0] snap;                      // Value captured on a snapshot
    logic        wr_clr;                    // Write to clear register

    // Decode helpers

    // Address match, used by the read and write paths
    function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
        hit = (a == ofs);
    endfunction : hit

    // Pack CTS and N in readback order, CTS first
    function automatic logic [39:0] pack_pair(input logic [19:0] cyc,
                                              input logic [19:0] dv);
        pack_pair = {cyc, dv};
    endfunction : pack_pair

    // Defined sampling frequency codes
    function automatic logic fs_known(input logic [3:0] c);
        unique case (c)
            4'h0, 4'h2, 4'h3, 4'h8,
            4'h9, 4'ha, 4'hc, 4'he: fs_known = 1'b1;  // see R17
            default:                fs_known = 1'b0;
        endcase
    endfunction : fs_known

    // Defined clock accuracy codes
    function automatic logic acc_known(input logic [1:0] c);
        acc_known = (c != 2'h3);                       // see R18
    endfunction : acc_known

    // Regeneration packet tracker
    acs_track u_track (
        .mclk     (mclk),
        .nrst     (nrst),
        .link_rst (link_rst),
        .pkt_stb  (pkt_stb),
        .pkt_div  (pkt_div),
        .pkt_cyc  (pkt_cyc),
        .tol      (s_q.tol_q),
        .irq_en   (s_q.ctl_q[`ACS_CTL_IRQ_EN_BIT]),
        .div_clr  (regen_divider_changed_clear),
        .over_clr (cycle_count_over_tolerance_clear),
        .div_val  (div_val),
        .cyc_val  (cyc_val),
        .seen     (regen_packet_seen),
        .div_chg  (div_chg),
        .over     (cycle_count_over_tolerance),
        .over_irq (cycle_count_over_tolerance_irq)
    );

    // Channel status collector
    acs_collect u_collect (
        .mclk      (mclk),
        .nrst      (nrst),
        .link_rst  (link_rst),
        .bit_stb   (cs_bit_stb),
        .bit_val   (cs_bit),
        .bit_chan  (cs_chan),
        .blk_start (cs_blk_start),
        .cs_data   (cs_data),
        .cs_valid  (cs_valid)
    );

    // Write side clear pulses

    // Clears are write-one pulses; the tracker lets a same-cycle event win
    always_comb begin
        wr_clr = reg_wr && hit(reg_addr, `ACS_OFS_CLR);
        regen_divider_changed_clear      = wr_clr && reg_wdata[`ACS_CHG_N_BIT];    // see R6
        cycle_count_over_tolerance_clear = wr_clr && reg_wdata[`ACS_CHG_CTO_BIT];  // see R7
    end

    // Register file next state
    always_comb begin
        s_d  = s_q;
        snap = pack_pair(cyc_val, div_val);
        s_d.rvalid_q = reg_rd;

        // Writable registers
        if (reg_wr && hit(reg_addr, `ACS_OFS_TOL)) begin
            s_d.tol_q = reg_wdata[5:0]; // see R8
        end
        if (reg_wr && hit(reg_addr, `ACS_OFS_CTL)) begin
            s_d.ctl_q = reg_wdata;
        end

        // Snapshot only on the first byte, so a block read that walks
        // 0x5B..0x5F sees one pair even if a packet lands meanwhile
        if (reg_rd && hit(reg_addr, `ACS_OFS_BUF0)) begin
            s_d.buf_q = snap; // see R1
        end

        // Read data; unmapped offsets and reserved bits read zero, except at 0x80, which reads back all 8 written bits
        if (reg_rd) begin
            unique case (reg_addr)
                `ACS_OFS_TOL: begin
                    s_d.rdata_q = {2'h0, s_q.tol_q}; // see R8
                end
                `ACS_OFS_CS0: begin
                    s_d.rdata_q = cs_data[7:0]; // see R13, R14
                end
                `ACS_OFS_CS1: begin
                    s_d.rdata_q = cs_data[15:8]; // see R15
                end
                `ACS_OFS_CS2: begin
                    s_d.rdata_q = cs_data[23:16]; // see R16
                end
                `ACS_OFS_CS3: begin
                    s_d.rdata_q = cs_data[31:24]; // see R17, R18
                end
                `ACS_OFS_CS4: begin
                    s_d.rdata_q = cs_data[39:32];
                end
                `ACS_OFS_BUF0: begin
                    s_d.rdata_q = snap[39:32]; // see R1, R4
                end
                `ACS_OFS_BUF1: begin
                    s_d.rdata_q = s_q.buf_q[31:24]; // see R2, R4
                end
                `ACS_OFS_BUF2: begin
                    s_d.rdata_q = s_q.buf_q[23:16]; // see R2, R3, R4
                end
                `ACS_OFS_BUF3: begin
                    s_d.rdata_q = s_q.buf_q[15:8]; // see R2, R3
                end
                `ACS_OFS_BUF4: begin
                    s_d.rdata_q = s_q.buf_q[7:0]; // see R2, R3
                end
                `ACS_OFS_RAW: begin
                    s_d.rdata_q = 8'h00;
                    s_d.rdata_q[`ACS_RAW_SEEN_BIT]  = regen_packet_seen;  // see R5
                    s_d.rdata_q[`ACS_RAW_VALID_BIT] = cs_valid;           // see R11
                end
                `ACS_OFS_CHG: begin
                    s_d.rdata_q = 8'h00;
                    s_d.rdata_q[`ACS_CHG_N_BIT]   = div_chg;                     // see R6
                    s_d.rdata_q[`ACS_CHG_CTO_BIT] = cycle_count_over_tolerance;  // see R7
                end
                `ACS_OFS_CTL: begin
                    s_d.rdata_q = s_q.ctl_q;
                end
                `ACS_OFS_IRQ: begin
                    s_d.rdata_q = 8'h00;
                    s_d.rdata_q[`ACS_CHG_CTO_BIT] = cycle_count_over_tolerance_irq; // see R9
                end
                default: begin
                    s_d.rdata_q = 8'h00;
                end
            endcase
        end
    end

    // Register file state
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            s_q       <= '0;
            s_q.tol_q <= `ACS_TOL_RST; // see R8
            s_q.ctl_q <= `ACS_CTL_RST;
        end else begin
            s_q <= s_d;
        end
    end

    // Outputs

    // Masks for the two interrupt outputs
    assign chan_status_valid_mask_a = s_q.ctl_q[`ACS_CTL_MASK_A_BIT];
    assign chan_status_valid_mask_b = s_q.ctl_q[`ACS_CTL_MASK_B_BIT];

    // Level outputs follow the valid flag, so they drop with link reset
    assign int_a = cs_valid && chan_status_valid_mask_a;             // see R12
    assign int_b = cs_valid && chan_status_valid_mask_b;             // see R12

    // Mute uses the same tolerance compare as the status bit
    assign mute_on_cycle_count_jump = cycle_count_over_tolerance &&
                                      s_q.ctl_q[`ACS_CTL_MUTE_BIT];  // see R9

    // Reserved-code flags for the decoded byte 3 fields
    assign cs_fs_reserved  = !fs_known(cs_data[27:24]);              // see R17
    assign cs_acc_reserved = !acc_known(cs_data[29:28]);             // see R18

    assign reg_rdata  = s_q.rdata_q;
    assign reg_rvalid = s_q.rvalid_q;

endmodule : acs_top

// *** acs_checker.sv ***
// Port-level assertions for the regeneration/status block
`timescale 1ns/1ps

module acs_checker (
    input wire logic       mclk,                     // Core clock
    input wire logic       nrst,                     // Async reset, active low
    input wire logic       link_rst,                 // Link reset
    input wire logic       pkt_stb,                  // Packet strobe
    input wire logic       cs_bit_stb,               // Status bit strobe
    input wire logic [7:0] reg_addr,                 // Register offset
    input wire logic       reg_wr,                   // Write strobe
    input wire logic       reg_rd,                   // Read strobe
    input wire logic [7:0] reg_rdata,                // Read data
    input wire logic       reg_rvalid,               // Read data strobe
    input wire logic       int_a,                    // Interrupt A
    input wire logic       int_b,                    // Interrupt B
    input wire logic       mute_on_cycle_count_jump, // Mute request
    input wire logic       cs_fs_reserved,           // Reserved rate code
    input wire logic       cs_acc_reserved           // Reserved accuracy code
);
    // One domain, so clock and reset are given once
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!nrst);

    // Read of an offset that maps to nothing
    sequence unmapped_rd_s;
        reg_rd && reg_addr == 8'h20;
    endsequence

    rd_answer_a: assert property (reg_rd |=> reg_rvalid)
        else $error("read not answered next cycle");
    rd_quiet_a: assert property (!reg_rd |=> !reg_rvalid)
        else $error("read strobe without request");
    rd_hold_a: assert property (!reg_rd |=> $stable(reg_rdata))
        else $error("read data moved without a read");
    unmapped_zero_a: assert property (unmapped_rd_s |=> reg_rvalid && reg_rdata == 8'h00)
        else $error("unmapped read not zero");
    int_a_cause_a: assert property ($rose(int_a) |-> $past(cs_bit_stb | reg_wr))
        else $error("int_a rose without cause");
    int_b_cause_a: assert property ($rose(int_b) |-> $past(cs_bit_stb | reg_wr))
        else $error("int_b rose without cause");
    int_drop_a: assert property ($fell(int_a) |-> $past(link_rst | reg_wr))
        else $error("int_a fell without cause");
    mute_rise_a: assert property ($rose(mute_on_cycle_count_jump) |-> $past(pkt_stb | reg_wr))
        else $error("mute rose without packet or write");
    mute_fall_a: assert property ($fell(mute_on_cycle_count_jump) |-> $past(reg_wr))
        else $error("mute fell without clear");
    fs_code_a: assert property ($changed(cs_fs_reserved) |-> $past(cs_bit_stb))
        else $error("rate flag moved without status bit");
    acc_code_a: assert property ($changed(cs_acc_reserved) |-> $past(cs_bit_stb))
        else $error("accuracy flag moved without status bit");
endmodule : acs_checker

bind acs_top acs_checker acs_checker_i (.mclk(mclk), .nrst(nrst), .link_rst(link_rst), .pkt_stb(pkt_stb),
    .cs_bit_stb(cs_bit_stb), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .reg_rvalid(reg_rvalid), .int_a(int_a), .int_b(int_b), .mute_on_cycle_count_jump(mute_on_cycle_count_jump),
    .cs_fs_reserved(cs_fs_reserved), .cs_acc_reserved(cs_acc_reserved));

// *** acs_src_model.sv ***
// Source model: regeneration packets and channel status bits
`timescale 1ns/1ps

module acs_src_model (
    input  wire logic        mclk,         // Core clock
    output logic             pkt_stb,      // Packet strobe
    output logic      [19:0] pkt_div,      // N
    output logic      [19:0] pkt_cyc,      // CTS
    output logic             cs_bit_stb,   // Status bit strobe
    output logic             cs_bit,       // Status bit
    output logic      [2:0]  cs_chan,      // Audio channel
    output logic             cs_blk_start  // Block start
);
    // Idle source at time zero
    initial begin
        {pkt_stb, cs_bit_stb, cs_bit, cs_blk_start} = 4'h0;
        {pkt_div, pkt_cyc, cs_chan} = 43'h0;
    end

    // N and CTS travel together; fields inverted after so stale values never match
    task automatic send_pkt(input logic [19:0] n, input logic [19:0] c);
        @(negedge mclk);
        pkt_stb = 1'b1;
        pkt_div = n;
        pkt_cyc = c;
        @(negedge mclk);
        pkt_stb = 1'b0;
        pkt_div = ~n;
        pkt_cyc = ~c;
    endtask : send_pkt

    // Bits LSB first from a block start; gap idles the strobe for a slow source
    task automatic send_cs(input logic [39:0] d, input logic [2:0] ch, input int gap, input int nb);
        for (int i = 0; i < nb; i++) begin
            @(negedge mclk);
            cs_bit_stb = 1'b1;
            cs_bit = d[i];
            cs_chan = ch;
            cs_blk_start = (i == 0);
            repeat (gap) begin
                @(negedge mclk);
                cs_bit_stb = 1'b0;
                cs_bit = ~cs_bit;
            end
        end
        @(negedge mclk);
        cs_bit_stb = 1'b0;
        cs_blk_start = 1'b0;
        cs_bit = ~cs_bit;
    endtask : send_cs
endmodule : acs_src_model

// *** acs_tb.sv ***
// Testbench: register readback, regeneration flags, channel status
`timescale 1ns/1ps
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin error_cnt++; $display("[ERR] t=%0t got %h exp %h", $time, a, b); end end

module tb;
    logic        mclk, nrst, link_rst, reg_wr, reg_rd; // Clock, resets, strobes
    logic [7:0]  reg_addr, reg_wdata, reg_rdata;       // Register port
    logic        reg_rvalid, int_a, int_b, mute, fs_res, acc_res; // Outputs
    logic        pkt_stb, cs_bit_stb, cs_bit, cs_blk_start; // Source strobes
    logic [19:0] pkt_div, pkt_cyc;                     // Packet fields
    logic [2:0]  cs_chan;                              // Audio channel
    int          error_cnt = 0;                        // Mismatches
    int          checks = 0;                           // Comparisons
    // Offset and reset value of eleven registers and of the unmapped offset 0x20
    logic [15:0] rows [12] = '{16'h1025, 16'h3600, 16'h3700, 16'h3800, 16'h3900, 16'h3a00,
                               16'h5b00, 16'h5e00, 16'h6500, 16'h7e00, 16'h8000, 16'h2000};
    logic [39:0] blk = 40'hc3_1e_21_05_0f;             // Emphasis 001, 192 kHz, level I

    acs_top acs_top_i (.mclk(mclk), .nrst(nrst), .link_rst(link_rst), .pkt_stb(pkt_stb), .pkt_div(pkt_div),
        .pkt_cyc(pkt_cyc), .cs_bit_stb(cs_bit_stb), .cs_bit(cs_bit), .cs_chan(cs_chan), .cs_blk_start(cs_blk_start),
        .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .reg_rvalid(reg_rvalid), .int_a(int_a), .int_b(int_b), .mute_on_cycle_count_jump(mute),
        .cs_fs_reserved(fs_res), .cs_acc_reserved(acc_res));
    acs_src_model src_i (.mclk(mclk), .pkt_stb(pkt_stb), .pkt_div(pkt_div), .pkt_cyc(pkt_cyc),
        .cs_bit_stb(cs_bit_stb), .cs_bit(cs_bit), .cs_chan(cs_chan), .cs_blk_start(cs_blk_start));

    // 25 MHz clock
    initial begin
        mclk = 1'b0;
        forever #20 mclk = ~mclk;
    end

    // Counts, verdict, end of run
    task automatic print_verdict();
        $display("checks %0d errors %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : print_verdict

    // One read; the answer strobe is awaited under a bound
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        int n;
        n = 0;
        @(negedge mclk);
        reg_addr = a;
        reg_rd = 1'b1;
        @(negedge mclk);
        reg_rd = 1'b0;
        while (reg_rvalid !== 1'b1 && n < 4) begin
            @(negedge mclk);
            n++;
        end
        `CHK(reg_rvalid, 1'b1)
        `CHK(reg_rdata, e)
        if (n == 4) begin
            error_cnt++;
            print_verdict();
        end
    endtask : rd

    // One write
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge mclk);
        {reg_addr, reg_wdata, reg_wr} = {a, d, 1'b1};
        @(negedge mclk);
        reg_wr = 1'b0;
    endtask : wr

    // Link reset for one cycle
    task automatic pulse_link();
        @(negedge mclk);
        link_rst = 1'b1;
        @(negedge mclk);
        link_rst = 1'b0;
    endtask : pulse_link

    // Hang guard
    initial begin
        repeat (20000) @(posedge mclk);
        error_cnt++;
        print_verdict();
    end

    // Main sequence
    initial begin
        {nrst, link_rst, reg_wr, reg_rd, reg_addr, reg_wdata} = 20'h0;
        repeat (3) @(posedge mclk);
        @(negedge mclk);
        nrst = 1'b1;
        foreach (rows[i]) rd(rows[i][15:8], rows[i][7:0]);
        $display("test reset values done");
        // First packet only marks seen; capture then a packet between block bytes
        src_i.send_pkt(20'h12345, 20'h6789a);
        rd(8'h65, 8'h02);
        rd(8'h7e, 8'h00);
        rd(8'h5b, 8'h67);
        src_i.send_pkt(20'h12345, 20'h678bf);
        rd(8'h5c, 8'h89);
        rd(8'h5d, 8'ha1);
        rd(8'h5e, 8'h23);
        rd(8'h5f, 8'h45);
        rd(8'h7e, 8'h00);
        wr(8'h80, 8'h24);
        src_i.send_pkt(20'h12345, 20'h67899);
        rd(8'h7e, 8'h10);
        rd(8'h81, 8'h10);
        `CHK(mute, 1'b1)
        src_i.send_pkt(20'h12346, 20'h67899);
        rd(8'h7e, 8'h18);
        wr(8'h7f, 8'h08);
        rd(8'h7e, 8'h10);
        wr(8'h7f, 8'h10);
        rd(8'h7e, 8'h00);
        rd(8'h81, 8'h00);
        `CHK(mute, 1'b0)
        wr(8'h10, 8'h07);
        rd(8'h10, 8'h07);
        src_i.send_pkt(20'h12346, 20'h678a1);
        rd(8'h7e, 8'h10);
        `CHK(mute, 1'b1)
        pulse_link();
        rd(8'h65, 8'h00);
        $display("test regeneration done");
        // Wrong channel, aborted block, then a full block
        wr(8'h80, 8'h03);
        src_i.send_cs(blk, 3'h1, 0, 40);
        rd(8'h65, 8'h00);
        src_i.send_cs({40{1'b1}}, 3'h0, 0, 10);
        src_i.send_cs(blk, 3'h0, 0, 40);
        for (int i = 0; i < 5; i++) rd(8'h36 + i[7:0], blk[8*i +: 8]);
        rd(8'h65, 8'h80);
        `CHK({int_a, int_b, fs_res, acc_res}, 4'hc)
        src_i.send_cs(40'h00_35_00_00_00, 3'h0, 2, 40);
        rd(8'h39, 8'h35);
        `CHK({fs_res, acc_res}, 2'b11)
        wr(8'h80, 8'h02);
        `CHK({int_a, int_b}, 2'b01)
        pulse_link();
        rd(8'h65, 8'h00);
        `CHK(int_b, 1'b0)
        $display("test channel status done");
        print_verdict();
    end
endmodule : tb
